/* ima_top.sv */
// Top of the I2C multi-master assist block with its AHB-Lite register slave.
// Assumes open-drain SCL/SDA with external pull-ups and a 125 MHz ref_clk.
//
// The AHB-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ima_top
  import ima_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic irq
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  ima_line_if line_bus ();
  logic en_q;
  logic [3:0] mode_q;
  logic hold_rel_q;
  logic [7:0] dir_q;
  logic [7:0] latch_q;
  logic [6:0] own_addr_q;
  logic start_q;
  logic stop_q;
  logic hold_q;
  logic [2:0] sts_q;
  logic [2:0] ena_q;
  logic ap_valid_q;
  logic ap_write_q;
  logic [7:0] ap_addr_q;
  logic wr_en;
  logic slave_active;
  logic ss_events;
  logic ack_drive;
  logic byte_done;
  logic [7:0] rx_byte;
  logic [2:0] sts_set;
  logic [2:0] sts_clr;

  // ****************************************************************
  // Line monitor and slave receiver
  // ****************************************************************
  ima_line_mon u_mon (
    .ref_clk(ref_clk),
    .reset(reset),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .line(line_bus)
  );

  // The slave only runs in the slave modes, so master-only mode leaves it idle.
  assign slave_active = en_q & ima_slave_on(mode_q);
  assign ss_events = en_q & ima_ss_irq_on(mode_q);

  ima_slave_rx u_slave (
    .ref_clk(ref_clk),
    .reset(reset),
    .active(slave_active),
    .own_addr(own_addr_q),
    .line(line_bus),
    .ack_drive(ack_drive),
    .byte_done(byte_done),
    .rx_byte(rx_byte)
  );

  // ****************************************************************
  // AHB-Lite slave
  // ****************************************************************
  // Register read data for the data phase, and the address phase itself.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ap_valid_q <= 1'b0;
      ap_write_q <= 1'b0;
      ap_addr_q <= 8'h00;
      hrdata <= 32'h0000_0000;
    end else begin
      ap_valid_q <= hsel & hready & htrans[1];
      ap_write_q <= hwrite;
      ap_addr_q <= haddr[7:0];
      if (hsel && hready && htrans[1] && !hwrite && haddr[31:8] == 24'h00_0000) begin
        case (haddr[7:0])
          IMA_OFF_CTRL: hrdata <= {26'h0, en_q, hold_rel_q, mode_q};
          IMA_OFF_FLAGS: hrdata <= {27'h0, stop_q, start_q, 3'h0};
          IMA_OFF_DIR: hrdata <= {24'h0, dir_q};
          // Pin levels read back at the line positions so firmware can check SDA.
          IMA_OFF_LATCH: hrdata <= {24'h0, latch_q[7], line_bus.scl, latch_q[5],
                                   line_bus.sda, latch_q[3:0]};
          IMA_OFF_RXDATA: hrdata <= {24'h0, rx_byte};
          IMA_OFF_ADDR: hrdata <= {25'h0, own_addr_q};
          IMA_OFF_IRQ_STS: hrdata <= {29'h0, sts_q};
          IMA_OFF_IRQ_ENA: hrdata <= {29'h0, ena_q};
          default: hrdata <= 32'h0000_0000;
        endcase
      end else begin
        hrdata <= 32'h0000_0000;
      end
    end
  end

  // Zero wait states and an OKAY answer to every transfer.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  assign wr_en = ap_valid_q & ap_write_q;

  // Control, direction, latch and address registers.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      en_q <= 1'b0;
      mode_q <= IMA_MODE_RESET;
      hold_rel_q <= IMA_HOLD_RESET;
      dir_q <= IMA_DIR_RESET;
      latch_q <= IMA_LATCH_RESET;
      own_addr_q <= IMA_ADDR_RESET;
      ena_q <= IMA_IRQ_RESET;
    end else if (wr_en) begin
      case (ap_addr_q)
        IMA_OFF_CTRL: begin
          mode_q <= hwdata[IMA_CTRL_MODE_LSB +: 4];
          hold_rel_q <= hwdata[IMA_CTRL_HOLD_BIT];
          en_q <= hwdata[IMA_CTRL_EN_BIT];
        end
        IMA_OFF_DIR: dir_q <= hwdata[7:0];
        IMA_OFF_LATCH: latch_q <= hwdata[7:0];
        IMA_OFF_ADDR: own_addr_q <= hwdata[6:0];
        IMA_OFF_IRQ_ENA: ena_q <= hwdata[2:0];
        default: en_q <= en_q;
      endcase
    end
  end

  // ****************************************************************
  // Bus condition flags and events
  // ****************************************************************
  // Start and Stop flags each show the latest condition and drop when disabled.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      start_q <= 1'b0;
      stop_q <= 1'b0;
    end else if (!en_q) begin
      start_q <= 1'b0;
      stop_q <= 1'b0;
    end else if (line_bus.start_p) begin
      start_q <= 1'b1;
      stop_q <= 1'b0;
    end else if (line_bus.stop_p) begin
      start_q <= 1'b0;
      stop_q <= 1'b1;
    end
  end

  assign sts_set[IMA_IRQ_START_BIT] = ss_events & line_bus.start_p;
  assign sts_set[IMA_IRQ_STOP_BIT] = ss_events & line_bus.stop_p;
  assign sts_set[IMA_IRQ_BYTE_BIT] = slave_active & byte_done;
  assign sts_clr = (wr_en && ap_addr_q == IMA_OFF_IRQ_CLR) ? hwdata[2:0] : 3'h0;

  // Sticky event bits; a new event wins over a clear in the same cycle.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sts_q <= IMA_IRQ_RESET;
    end else begin
      sts_q <= (sts_q & ~sts_clr) | sts_set;
    end
  end

  // The interrupt is high while any enabled event bit is set.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(sts_q & ena_q);
    end
  end

  // ****************************************************************
  // Clock hold and pin drive
  // ****************************************************************
  // Holding starts only once SCL is already low and ends when the bit is set again.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      hold_q <= 1'b0;
    end else if (!en_q || hold_rel_q) begin
      hold_q <= 1'b0;
    end else if (!line_bus.scl) begin
      hold_q <= 1'b1;
    end
  end

  // Pins only ever pull low; a set direction bit floats the line high unless hold (SCL) or ack_drive (SDA) pulls it.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      scl_oe <= ~dir_q[IMA_DIR_SCL_BIT] | hold_q;
      sda_oe <= ~dir_q[IMA_DIR_SDA_BIT] | ack_drive;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence s_stop_to_irq;
    line_bus.stop_p ##1 sts_q[IMA_IRQ_STOP_BIT] ##1 irq;
  endsequence

  property p_flags_off;
    @(posedge ref_clk) disable iff (reset)
      !en_q |=> !start_q && !stop_q;
  endproperty
  a_flags_off: assert property (p_flags_off) else $error("Flags survived disable");

  property p_start_flag;
    @(posedge ref_clk) disable iff (reset)
      en_q && line_bus.start_p |=> start_q && !stop_q;
  endproperty
  a_start_flag: assert property (p_start_flag) else $error("Start flag not updated");

  property p_stop_flag;
    @(posedge ref_clk) disable iff (reset)
      en_q && line_bus.stop_p && !line_bus.start_p |=> stop_q && !start_q;
  endproperty
  a_stop_flag: assert property (p_stop_flag) else $error("Stop flag not updated");

  property p_pins_low;
    @(posedge ref_clk) disable iff (reset)
      !scl_out && !sda_out;
  endproperty
  a_pins_low: assert property (p_pins_low) else $error("Pin driven high");

  property p_sda_float;
    @(posedge ref_clk) disable iff (reset)
      dir_q[IMA_DIR_SDA_BIT] && !ack_drive |=> !sda_oe;
  endproperty
  a_sda_float: assert property (p_sda_float) else $error("SDA driven while released");

  property p_start_event;
    @(posedge ref_clk) disable iff (reset)
      ss_events && line_bus.start_p |=> sts_q[IMA_IRQ_START_BIT];
  endproperty
  a_start_event: assert property (p_start_event) else $error("Start event missed");

  property p_stop_irq;
    @(posedge ref_clk) disable iff (reset)
      ss_events && line_bus.stop_p && ena_q[IMA_IRQ_STOP_BIT] && !wr_en |-> s_stop_to_irq;
  endproperty
  a_stop_irq: assert property (p_stop_irq) else $error("Stop did not interrupt");

  property p_hold_drives;
    @(posedge ref_clk) disable iff (reset)
      hold_q |=> scl_oe;
  endproperty
  a_hold_drives: assert property (p_hold_drives) else $error("Hold did not pull SCL");

  property p_hold_after_low;
    @(posedge ref_clk) disable iff (reset)
      $rose(hold_q) |-> !$past(line_bus.scl);
  endproperty
  a_hold_after_low: assert property (p_hold_after_low) else $error("Hold before SCL low");

  property p_hold_keeps;
    @(posedge ref_clk) disable iff (reset)
      hold_q && en_q && !hold_rel_q |=> hold_q;
  endproperty
  a_hold_keeps: assert property (p_hold_keeps) else $error("Hold dropped early");

endmodule
`default_nettype wire

/* ima_pkg.sv */
// Shared constants, types and decode helpers for the I2C multi-master assist block.
// Assumes a 32-bit AHB-Lite register bus and one system clock domain.
package ima_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] IMA_OFF_CTRL = 8'h00;
  localparam logic [7:0] IMA_OFF_FLAGS = 8'h04;
  localparam logic [7:0] IMA_OFF_DIR = 8'h08;
  localparam logic [7:0] IMA_OFF_LATCH = 8'h0c;
  localparam logic [7:0] IMA_OFF_RXDATA = 8'h10;
  localparam logic [7:0] IMA_OFF_ADDR = 8'h14;
  localparam logic [7:0] IMA_OFF_IRQ_STS = 8'h18;
  localparam logic [7:0] IMA_OFF_IRQ_CLR = 8'h1c;
  localparam logic [7:0] IMA_OFF_IRQ_ENA = 8'h20;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int IMA_CTRL_MODE_LSB = 0;
  localparam int IMA_CTRL_HOLD_BIT = 4;
  localparam int IMA_CTRL_EN_BIT = 5;
  localparam logic [3:0] IMA_MODE_RESET = 4'h0;
  localparam logic IMA_HOLD_RESET = 1'b1;
  localparam int IMA_FLAG_STOP_BIT = 4;
  localparam int IMA_FLAG_START_BIT = 3;
  localparam int IMA_DIR_SCL_BIT = 6;
  localparam int IMA_DIR_SDA_BIT = 4;
  localparam logic [7:0] IMA_DIR_RESET = 8'hf0;
  localparam logic [7:0] IMA_LATCH_RESET = 8'h00;
  localparam logic [6:0] IMA_ADDR_RESET = 7'h00;
  localparam int IMA_IRQ_START_BIT = 0;
  localparam int IMA_IRQ_STOP_BIT = 1;
  localparam int IMA_IRQ_BYTE_BIT = 2;
  localparam logic [2:0] IMA_IRQ_RESET = 3'h0;
  localparam logic [3:0] IMA_BITS_PER_BYTE = 4'h8;

  // ****************************************************************
  // Port modes
  // ****************************************************************
  localparam logic [3:0] IMA_MODE_SLAVE7 = 4'h6;
  localparam logic [3:0] IMA_MODE_MASTER_IDLE = 4'hb;
  localparam logic [3:0] IMA_MODE_SLAVE7_SS = 4'he;

  typedef enum logic [1:0] {
    IMA_SL_IDLE,
    IMA_SL_SHIFT,
    IMA_SL_ACK,
    IMA_SL_SKIP
  } ima_slave_state_t;

  // True when the mode keeps the slave receiver running.
  function automatic logic ima_slave_on(input logic [3:0] mode);
    return (mode == IMA_MODE_SLAVE7) || (mode == IMA_MODE_SLAVE7_SS);
  endfunction

  // True when the mode raises events on Start and Stop conditions.
  function automatic logic ima_ss_irq_on(input logic [3:0] mode);
    return (mode == IMA_MODE_MASTER_IDLE) || (mode == IMA_MODE_SLAVE7_SS);
  endfunction

endpackage

/* ima_line_if.sv */
// Interface carrying the synchronised bus line levels and bus events.
// Assumes one driver (the line monitor) and any number of readers on ref_clk.
`timescale 1ns/1ps
`default_nettype none
interface ima_line_if;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_p;
  logic stop_p;

  modport mon (output scl, output sda, output scl_rise, output scl_fall,
               output start_p, output stop_p);
  modport use_side (input scl, input sda, input scl_rise, input scl_fall,
                    input start_p, input stop_p);
endinterface
`default_nettype wire

/* ima_line_mon.sv */
// Line monitor: synchronises SCL and SDA and finds edges, Start and Stop.
// Assumes raw open-drain pin levels from outside the ref_clk domain.
`timescale 1ns/1ps
`default_nettype none
module ima_line_mon
  import ima_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic scl_in,
  input wire logic sda_in,
  ima_line_if.mon line
);

  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic scl_prev_q;
  logic sda_prev_q;

  // Two-stage synchronisers; only the second stage is read by logic.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
    end else begin
      scl_sync_q <= {scl_sync_q[0], scl_in};
      sda_sync_q <= {sda_sync_q[0], sda_in};
    end
  end

  // Previous levels for edge detection.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_sync_q[1];
      sda_prev_q <= sda_sync_q[1];
    end
  end

  // SDA moving while SCL stays high marks Start (falling) or Stop (rising).
  assign line.scl = scl_sync_q[1];
  assign line.sda = sda_sync_q[1];
  assign line.scl_rise = scl_sync_q[1] & ~scl_prev_q;
  assign line.scl_fall = ~scl_sync_q[1] & scl_prev_q;
  assign line.start_p = scl_sync_q[1] & scl_prev_q & sda_prev_q & ~sda_sync_q[1];
  assign line.stop_p = scl_sync_q[1] & scl_prev_q & ~sda_prev_q & sda_sync_q[1];

endmodule
`default_nettype wire

/* ima_slave_rx.sv */
// Slave receiver: shifts in bytes, matches the own address and drives ACK.
// Assumes line events from ima_line_mon on the same ref_clk.
`timescale 1ns/1ps
`default_nettype none
module ima_slave_rx
  import ima_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic active,
  input wire logic [6:0] own_addr,
  ima_line_if.use_side line,
  output logic ack_drive,
  output logic byte_done,
  output logic [7:0] rx_byte
);

  ima_slave_state_t state_q;
  logic [7:0] shift_q;
  logic [3:0] cnt_q;
  logic first_q;
  logic addressed_q;
  logic match;

  // A write to our own address, or any byte once we are addressed, is acknowledged.
  assign match = first_q ? (shift_q[7:1] == own_addr) && !shift_q[0] : addressed_q;

  // Receive sequence; it returns to idle on a Stop or whenever the slave is not active.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_q <= IMA_SL_IDLE;
      shift_q <= 8'h00;
      cnt_q <= 4'h0;
      first_q <= 1'b0;
      addressed_q <= 1'b0;
      ack_drive <= 1'b0;
      byte_done <= 1'b0;
      rx_byte <= 8'h00;
    end else begin
      byte_done <= 1'b0;
      if (!active || line.stop_p) begin
        state_q <= IMA_SL_IDLE;
        addressed_q <= 1'b0;
        ack_drive <= 1'b0;
      end else if (line.start_p) begin
        state_q <= IMA_SL_SHIFT;
        cnt_q <= 4'h0;
        first_q <= 1'b1;
        addressed_q <= 1'b0;
        ack_drive <= 1'b0;
      end else begin
        case (state_q)
          IMA_SL_SHIFT: begin
            if (line.scl_rise && cnt_q != IMA_BITS_PER_BYTE) begin
              shift_q <= {shift_q[6:0], line.sda};
              cnt_q <= cnt_q + 4'h1;
            end else if (line.scl_fall && cnt_q == IMA_BITS_PER_BYTE) begin
              state_q <= IMA_SL_ACK;
              ack_drive <= match;
              byte_done <= match;
              addressed_q <= match;
              rx_byte <= shift_q;
            end
          end
          IMA_SL_ACK: begin
            if (line.scl_fall) begin
              ack_drive <= 1'b0;
              cnt_q <= 4'h0;
              first_q <= 1'b0;
              state_q <= addressed_q ? IMA_SL_SHIFT : IMA_SL_SKIP;
            end
          end
          IMA_SL_SKIP: state_q <= IMA_SL_SKIP;
          IMA_SL_IDLE: state_q <= IMA_SL_IDLE;
          default: state_q <= IMA_SL_IDLE;
        endcase
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_ack_on_fall;
    @(posedge ref_clk) disable iff (reset)
      $rose(ack_drive) |-> $past(line.scl_fall) && $past(cnt_q) == IMA_BITS_PER_BYTE;
  endproperty
  a_ack_on_fall: assert property (p_ack_on_fall) else $error("ACK began off the ninth clock");

endmodule
`default_nettype wire

/* ima_bus_partner.sv */
// Behavioural I2C master that stands on the far side of the assist block.
// Assumes the bench resolves the open-drain lines with pull-ups; SCL period 80 ns.
`timescale 1ns/1ps
`default_nettype none
module ima_bus_partner (
  input wire logic scl_line,
  input wire logic sda_line,
  output logic scl_pull,
  output logic sda_pull
);
  // ********
  // Line control
  // ********
  // Both lines are released at time zero, so the pull-ups hold them high.
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end

  // Pulls or releases each line directly, for holds outside a frame.
  task automatic hold_lines(input logic scl_low, input logic sda_low);
    scl_pull = scl_low;
    sda_pull = sda_low;
  endtask

  // Start: SDA falls while SCL is high, then SCL is pulled low.
  task automatic bus_start();
    sda_pull = 1'b1;
    #40;
    scl_pull = 1'b1;
    #20;
  endtask

  // Stop: SDA rises while SCL is high; SCL then stands still.
  task automatic bus_stop();
    sda_pull = 1'b1;
    #20;
    scl_pull = 1'b0;
    #40;
    sda_pull = 1'b0;
    #40;
  endtask

  // One clock: release SCL, wait out any stretch, sample SDA late in the high phase.
  task automatic clock_bit(output logic seen);
    #20;
    scl_pull = 1'b0;
    wait (scl_line === 1'b1);
    #40;
    seen = sda_line;
    scl_pull = 1'b1;
    #20;
  endtask

  // Sends a byte MSB first and reports whether the ninth clock saw SDA low.
  task automatic send_byte(input logic [7:0] data, output logic ack_low);
    logic seen;
    for (int i = 7; i >= 0; i--) begin
      sda_pull = !data[i];
      clock_bit(seen);
    end
    sda_pull = 1'b0;
    clock_bit(seen);
    ack_low = !seen;
  endtask
endmodule
`default_nettype wire

/* test_i2c_multimaster_assist.sv */
// Self-checking bench for the I2C multi-master assist block.
// Assumes ima_top with its AHB-Lite slave and the partner model ima_bus_partner.
`timescale 1ns/1ps
`default_nettype none
module test_i2c_multimaster_assist import ima_pkg::*;;
  logic ref_clk;
  logic reset;
  logic hsel;
  logic hwrite;
  logic [1:0] htrans;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic scl_out;
  logic scl_oe;
  logic sda_out;
  logic sda_oe;
  logic irq;
  logic p_scl_pull;
  logic p_sda_pull;
  logic ack;
  wire scl_line;
  wire sda_line;
  int err_count = 0;
  int compares = 0;
  int cycles = 0;

  // Open-drain lines with pull-ups: low while any party pulls.
  assign scl_line = !(scl_oe | p_scl_pull);
  assign sda_line = !(sda_oe | p_sda_pull);

  ima_top DUT (
    .ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .scl_in(scl_line),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .irq(irq)
  );

  ima_bus_partner partner (
    .scl_line(scl_line), .sda_line(sda_line), .scl_pull(p_scl_pull), .sda_pull(p_sda_pull)
  );

  // ********
  // Clock, timeout and reporting
  // ********
  // Free-running 125 MHz system clock.
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // Cuts a hang short well beyond the length of the whole run.
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      err_count++;
      $display("unexpected timeout expected 0 seen %0d", cycles);
      end_of_test();
    end
  end

  // Prints the counts and the verdict, then stops.
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Compares one value and reports a mismatch at once.
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  // ********
  // Register bus master
  // ********
  // One single AHB-Lite transfer: address phase, then data phase, each held until hready.
  task automatic bus_xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                          output logic [31:0] rd);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // Writes one register.
  task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    bus_xfer(1'b1, a, d, rd);
  endtask

  // Reads one register and compares it.
  task automatic read_check(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    bus_xfer(1'b0, a, 32'h0, rd);
    check(what, exp, rd);
  endtask

  // ********
  // Tests
  // ********
  // Reset, then pins, events, slave receiver and clock hold in turn.
  initial begin
    reset = 1'b1;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    read_check("ctrl", IMA_OFF_CTRL, 32'h10);
    read_check("dir", IMA_OFF_DIR, 32'hf0);
    read_check("flags", IMA_OFF_FLAGS, 32'h0);
    read_check("irq_sts", IMA_OFF_IRQ_STS, 32'h0);
    read_check("unmapped", 8'h40, 32'h0);
    check("oe_reset", 32'h0, {30'h0, scl_oe, sda_oe});
    check("hresp", 32'h0, {31'h0, hresp});
    $display("test reset done");
    write_reg(IMA_OFF_LATCH, 32'hff);
    write_reg(IMA_OFF_DIR, 32'ha0);
    repeat (4) @(posedge ref_clk);
    check("pin_drive", 32'h3, {30'h0, scl_oe, sda_oe});
    check("pin_level", 32'h0, {30'h0, scl_out, sda_out});
    read_check("latch_low", IMA_OFF_LATCH, 32'haf);
    write_reg(IMA_OFF_DIR, 32'hf0);
    repeat (4) @(posedge ref_clk);
    check("pin_free", 32'h0, {30'h0, scl_oe, sda_oe});
    partner.hold_lines(1'b0, 1'b1);
    repeat (4) @(posedge ref_clk); // Lets the pin pass the synchroniser.
    read_check("latch_sda", IMA_OFF_LATCH, 32'hef);
    partner.hold_lines(1'b0, 1'b0);
    repeat (4) @(posedge ref_clk); // The Stop seen here falls while still disabled.
    $display("test pins done");
    write_reg(IMA_OFF_CTRL, 32'h3b);
    write_reg(IMA_OFF_IRQ_ENA, 32'h3);
    partner.bus_start();
    read_check("flags_start", IMA_OFF_FLAGS, 32'h08);
    read_check("sts_start", IMA_OFF_IRQ_STS, 32'h1);
    check("irq_start", 32'h1, {31'h0, irq});
    write_reg(IMA_OFF_IRQ_CLR, 32'h7);
    read_check("sts_clr", IMA_OFF_IRQ_STS, 32'h0);
    check("irq_clr", 32'h0, {31'h0, irq});
    partner.bus_stop();
    read_check("flags_stop", IMA_OFF_FLAGS, 32'h10);
    check("irq_stop", 32'h1, {31'h0, irq});
    write_reg(IMA_OFF_IRQ_ENA, 32'h1);
    read_check("sts_masked", IMA_OFF_IRQ_STS, 32'h2);
    check("irq_masked", 32'h0, {31'h0, irq});
    write_reg(IMA_OFF_CTRL, 32'h1b);
    read_check("flags_off", IMA_OFF_FLAGS, 32'h0);
    $display("test events done");
    write_reg(IMA_OFF_ADDR, 32'h2a);
    write_reg(IMA_OFF_IRQ_ENA, 32'h4);
    write_reg(IMA_OFF_CTRL, 32'h3e);
    write_reg(IMA_OFF_IRQ_CLR, 32'h7);
    partner.bus_start();
    partner.send_byte(8'h54, ack);
    check("ack_own", 32'h1, {31'h0, ack});
    partner.send_byte(8'hc3, ack);
    check("ack_data", 32'h1, {31'h0, ack});
    partner.bus_stop();
    read_check("rxdata", IMA_OFF_RXDATA, 32'hc3);
    read_check("sts_slave", IMA_OFF_IRQ_STS, 32'h7);
    check("irq_byte", 32'h1, {31'h0, irq});
    partner.bus_start();
    partner.send_byte(8'h56, ack);
    check("ack_other", 32'h0, {31'h0, ack});
    partner.bus_stop();
    $display("test slave done");
    write_reg(IMA_OFF_CTRL, 32'h2b);
    repeat (8) @(posedge ref_clk);
    check("hold_wait", 32'h0, {31'h0, scl_oe});
    partner.hold_lines(1'b1, 1'b0);
    #80;
    partner.hold_lines(1'b0, 1'b0);
    repeat (4) @(posedge ref_clk);
    check("hold_low", 32'h1, {31'h0, scl_oe});
    check("scl_held", 32'h0, {31'h0, scl_line});
    write_reg(IMA_OFF_CTRL, 32'h3b);
    repeat (4) @(posedge ref_clk);
    check("hold_free", 32'h1, {31'h0, scl_line});
    $display("test clock hold done");
    end_of_test();
  end
endmodule
`default_nettype wire
